//--- core/sse_exec.sv
`timescale 1ns/1ns
`default_nettype none
module sse_exec (
	// Clock and reset
	input  wire logic                  ref_clk_in,
	input  wire logic                  srst_in,
	// Instruction, operands and watchdog tick
	input  wire logic                  instr_valid_in,
	input  wire logic [11:0]           instr_in,
	input  wire logic [7:0]            file_rd_data_in,
	input  wire logic                  watchdog_tick_in,
	// Results
	output logic [4:0]                 file_rd_addr_out,
	output sse_pkg::sse_file_wr_t      file_wr_out,
	output logic [7:0]                 acc_out,
	output sse_pkg::sse_alu_flags_t    flags_out,
	output logic [7:0]                 watchdog_counter_out,
	output logic [7:0]                 watchdog_prescaler_out,
	output logic                       timeout_flag_n_out,
	output logic                       powerdown_flag_n_out,
	output logic                       pin_change_wake_flag_n_out,
	output logic                       osc_halt_out
);
	import sse_pkg::*;

	// ----------------------------------------
	// Instruction fields
	// ----------------------------------------
	logic       is_sleep;
	logic       is_sub;
	logic       dest;
	logic [4:0] file_addr;

	// (RL1) sleep opcode match
	assign is_sleep  = instr_valid_in && (instr_in == SSE_OP_SLEEP);
	// (RL6) subtract opcode match
	// The destination bit lies below the match field, so both destinations decode
	assign is_sub    = instr_valid_in && (instr_in[SSE_OP_SUB_TOP:SSE_OP_SUB_LOW] == SSE_OP_SUB_MATCH);
	assign dest      = instr_in[SSE_DEST_BIT];
	assign file_addr = instr_in[SSE_ADDR_TOP:0];

	// ----------------------------------------
	// Operand path
	// ----------------------------------------
	// Address leaves combinationally so the operand comes back in the same cycle;
	// a registered address would cost the single-cycle execution
	assign file_rd_addr_out = file_addr;

	// ----------------------------------------
	// Subtractor
	// ----------------------------------------
	logic [7:0] acc_inv;
	logic [8:0] chain;
	logic [7:0] diff;
	logic       no_borrow;
	logic       no_borrow_lo;

	// (RL6) file plus inverted accumulator plus one
	// chain[i] is the carry into bit i; a carry out means no borrow
	assign acc_inv  = ~acc_out;
	assign chain[0] = 1'b1;

	for (genvar i = 0; i < 8; i++) begin : g_sub_bit
		logic half;
		assign half         = file_rd_data_in[i] ^ acc_inv[i];
		assign diff[i]      = half ^ chain[i];
		assign chain[i + 1] = (file_rd_data_in[i] & acc_inv[i]) | (chain[i] & half);
	end

	// (RL10) difference wraps modulo 256
	assign no_borrow    = chain[8];
	// (RL11) carry out of low nibble
	assign no_borrow_lo = chain[4];

	// ----------------------------------------
	// Accumulator
	// ----------------------------------------
	// (RL5) sleep leaves accumulator alone
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			acc_out <= SSE_ACC_RESET;
		// (RL7) destination accumulator
		end else if (is_sub && !dest) begin
			acc_out <= diff;
		end
	end

	// ----------------------------------------
	// File register write
	// ----------------------------------------
	// Address and data load every cycle; they are meaningful only while the strobe is up
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			file_wr_out <= '0;
		end else begin
			// (RL8) destination file register
			file_wr_out.en   <= is_sub && dest;
			file_wr_out.addr <= file_addr;
			file_wr_out.data <= diff;
		end
	end

	// ----------------------------------------
	// Arithmetic flags
	// ----------------------------------------
	// (RL5) sleep leaves flags alone
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			flags_out <= '0;
		end else if (is_sub) begin
			// (RL9) carry means no borrow
			flags_out.carry       <= no_borrow;
			// (RL11) digit carry and zero
			flags_out.digit_carry <= no_borrow_lo;
			flags_out.zero        <= (diff == 8'h00);
		end
	end

	// ----------------------------------------
	// Watchdog prescaler
	// ----------------------------------------
	logic prescaler_wrap;

	// The counter only moves on the tick that rolls the prescaler over
	assign prescaler_wrap = watchdog_tick_in && (watchdog_prescaler_out == 8'hff);

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			watchdog_prescaler_out <= SSE_PRE_CLEAR;
		// (RL2) clear prescaler
		end else if (is_sleep) begin
			watchdog_prescaler_out <= SSE_PRE_CLEAR;
		end else if (watchdog_tick_in) begin
			watchdog_prescaler_out <= watchdog_prescaler_out + 8'h01;
		end
	end

	// ----------------------------------------
	// Watchdog counter
	// ----------------------------------------
	// A tick in the sleep cycle is dropped: the clear wins, so the sleep period starts whole.
	// Overflow of the counter into a timeout is handled outside this block.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			watchdog_counter_out <= SSE_WDT_CLEAR;
		// (RL2) clear watchdog counter
		end else if (is_sleep) begin
			watchdog_counter_out <= SSE_WDT_CLEAR;
		end else if (prescaler_wrap) begin
			watchdog_counter_out <= watchdog_counter_out + 8'h01;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Only the sleep side of each flag lives here; wake-up and timeout events act elsewhere
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			timeout_flag_n_out <= SSE_TO_RESET;
		// (RL3) timeout flag set
		end else if (is_sleep) begin
			timeout_flag_n_out <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			powerdown_flag_n_out <= SSE_PD_RESET;
		// (RL4) power-down flag cleared
		end else if (is_sleep) begin
			powerdown_flag_n_out <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			pin_change_wake_flag_n_out <= SSE_WAKE_RESET;
		// (RL5) wake flag set
		end else if (is_sleep) begin
			pin_change_wake_flag_n_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// Run state and oscillator
	// ----------------------------------------
	typedef enum logic {
		SSE_ST_RUN,
		SSE_ST_ASLEEP
	} sse_run_state_t;

	sse_run_state_t run_state;

	// Asleep is held until reset; wake-up sequencing is outside this block
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			run_state <= SSE_ST_RUN;
		end else begin
			case (run_state)
				SSE_ST_RUN: begin
					// (RL1) enter low-power state
					if (is_sleep) begin
						run_state <= SSE_ST_ASLEEP;
					end
				end
				SSE_ST_ASLEEP: begin
					run_state <= SSE_ST_ASLEEP;
				end
				default: begin
					run_state <= SSE_ST_RUN;
				end
			endcase
		end
	end

	// Halt has its own flop so the output stays registered and rises right after the sleep edge
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			osc_halt_out <= 1'b0;
		end else begin
			case (run_state)
				SSE_ST_RUN: begin
					// (RL1) stop oscillator
					osc_halt_out <= is_sleep;
				end
				SSE_ST_ASLEEP: begin
					osc_halt_out <= 1'b1;
				end
				default: begin
					osc_halt_out <= 1'b0;
				end
			endcase
		end
	end
endmodule : sse_exec
`default_nettype wire

//--- core/sse_pkg.sv
// Functional notes
// (RL1) Power-down opcode halts oscillator, one cycle; the code holds osc_halt_out high until reset
// (RL2) Power-down clears watchdog counter and prescaler
// (RL3) Power-down sets active-low timeout flag
// (RL4) Power-down clears active-low power-down flag
// (RL5) Power-down sets wake flag, arithmetic untouched
// (RL6) Subtract opcode: file minus accumulator
// (RL7) Destination zero writes accumulator only
// (RL8) Destination one writes file register only
// (RL9) Carry set when file >= accumulator
// (RL10) Carry cleared on borrow, difference wraps
// (RL11) Zero and digit carry from difference
package sse_pkg;
	localparam logic [11:0] SSE_OP_SLEEP      = 12'h003;
	localparam logic [5:0]  SSE_OP_SUB_MATCH  = 6'h02;
	localparam int          SSE_OP_SUB_TOP    = 11;
	localparam int          SSE_OP_SUB_LOW    = 6;
	localparam int          SSE_DEST_BIT      = 5;
	localparam int          SSE_ADDR_TOP      = 4;
	localparam logic [7:0]  SSE_WDT_CLEAR     = 8'h00;
	localparam logic [7:0]  SSE_PRE_CLEAR     = 8'h00;
	localparam logic [7:0]  SSE_ACC_RESET     = 8'h00;
	localparam logic        SSE_TO_RESET      = 1'b1;
	localparam logic        SSE_PD_RESET      = 1'b1;
	localparam logic        SSE_WAKE_RESET    = 1'b1;

	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic zero;
	} sse_alu_flags_t;

	typedef struct packed {
		logic       en;
		logic [4:0] addr;
		logic [7:0] data;
	} sse_file_wr_t;
endpackage : sse_pkg

//--- verification/sse_exec_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sse_exec_monitor import sse_pkg::*; (
	input wire logic ref_clk_in,srst_in,instr_valid_in,powerdown_flag_n_out,osc_halt_out,timeout_flag_n_out,
	input wire logic pin_change_wake_flag_n_out,
	input wire logic [11:0] instr_in,
	input wire logic [7:0] file_rd_data_in,acc_out,watchdog_counter_out,watchdog_prescaler_out,
	input wire sse_file_wr_t file_wr_out,
	input wire sse_alu_flags_t flags_out
);
	logic s,u,b,h;
	logic [4:0] a;
	logic [7:0] d;
	assign h=file_rd_data_in[3:0]>=acc_out[3:0];
	assign a=instr_in[4:0];
	assign s=instr_valid_in&&instr_in==SSE_OP_SLEEP;
	assign u=instr_valid_in&&instr_in[11:6]==6'h02;
	assign d=file_rd_data_in-acc_out;
	assign b=file_rd_data_in<acc_out;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	AST_HALT: assert property (s|=>osc_halt_out[*2]) else $error("halt");
	AST_WDT: assert property (s|=>watchdog_counter_out==8'h00) else $error("wdt");
	AST_PWRDN: assert property (s|=>!powerdown_flag_n_out) else $error("pd");
	AST_KEEP: assert property (s|=>$stable(acc_out)&&$stable(flags_out)) else $error("keep");
	AST_ACC: assert property (u&&!instr_in[5]|=>acc_out==$past(d)&&!file_wr_out.en) else $error("acc");
	AST_FILE: assert property (u&&instr_in[5]|=>file_wr_out.en&&file_wr_out.data==$past(d)&&file_wr_out.addr==$past(a)) else $error("f");
	AST_PRE: assert property (s|=>watchdog_prescaler_out==8'h00) else $error("pre");
	AST_TIMEOUT: assert property (s|=>timeout_flag_n_out) else $error("timeout");
	AST_WAKE: assert property (s|=>pin_change_wake_flag_n_out) else $error("wake");
	AST_DCARRY: assert property (u|=>flags_out.digit_carry==$past(h)) else $error("dc");
	AST_IDLE: assert property (!s&&!u|=>$stable(acc_out)&&$stable(flags_out)&&!file_wr_out.en) else $error("idle");
	AST_CARRY: assert property (u|=>flags_out.carry!=$past(b)) else $error("carry");
	AST_ZERO: assert property (u|=>flags_out.zero==($past(d)==8'h0)) else $error("zero");
endmodule : sse_exec_monitor
bind sse_exec sse_exec_monitor mon(.*);
`default_nettype wire

//--- verification/sleep_and_subtract_exec_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sleep_and_subtract_exec_bench;
	import sse_pkg::*;
	logic ref_clk_in=0,srst_in=1,instr_valid_in=0,watchdog_tick_in=0,due=0,timeout_flag_n_out,powerdown_flag_n_out,
		pin_change_wake_flag_n_out,osc_halt_out;
	logic [11:0] instr_in=0;
	logic [7:0] file_rd_data_in=0,acc_out,watchdog_counter_out,watchdog_prescaler_out,acc=0,pre=0;
	logic [4:0] file_rd_addr_out;
	logic [15:0] r=16'h1;
	logic [44:0] o;
	logic [49:0] q[$],e;
	logic [4:0] a;
	sse_file_wr_t file_wr_out,w;
	sse_alu_flags_t flags_out,fl=0;
	int bad_count=0,n_compared=0;
	always #4 ref_clk_in=~ref_clk_in;
	always @(posedge ref_clk_in) due<=instr_valid_in;
	sse_exec dut(.*);
	// Write data is only meaningful while the strobe is up
	assign o={acc_out,file_wr_out.en?file_wr_out:14'h0,flags_out,watchdog_counter_out,watchdog_prescaler_out,
		timeout_flag_n_out,powerdown_flag_n_out,pin_change_wake_flag_n_out,osc_halt_out};
	always @(posedge ref_clk_in) begin
		a=file_rd_addr_out;
		#2;
		if (due) begin
			e=q.pop_front();
			n_compared++;
			if ({o,a}!==e) begin
				$display("ERROR outputs exp %h got %h",e,{o,a});
				bad_count++;
			end
		end
	end
	function automatic logic [15:0] lf(input logic [15:0] s);
		return {s[14:0],s[15]^s[13]^s[12]^s[10]};
	endfunction : lf
	task automatic go(input logic [11:0] op,input logic [7:0] d,input logic t);
		logic [8:0] df;
		df={1'b0,d}-{1'b0,acc};
		w=14'h0;
		if (op[11:6]==6'h02) begin
			fl={!df[8],d[3:0]>=acc[3:0],df[7:0]==8'h0};
			if (op[5]) w={1'b1,op[4:0],df[7:0]};
			else acc=df[7:0];
		end
		pre=op==SSE_OP_SLEEP?8'h0:pre+t;
		q.push_back({acc,w,fl,8'h0,pre,1'b1,op!=SSE_OP_SLEEP,1'b1,op==SSE_OP_SLEEP,op[4:0]});
		{instr_in,file_rd_data_in,watchdog_tick_in,instr_valid_in}={op,d,t,1'b1};
		@(posedge ref_clk_in);
		#1;
	endtask : go
	task results;
		if (q.size()) bad_count++;
		$display("compared %0d bad %0d",n_compared,bad_count);
		if (bad_count==0&&n_compared>0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	initial begin
		repeat (4) @(posedge ref_clk_in);
		#1;
		srst_in=0;
		for (int i=0;i<40;i++) begin
			r=lf(r);
			go({6'h02,r[5:0]},i%8?r[15:8]:acc,r[6]);
		end
		$display("subtract test done");
		go(12'h0e5,8'h55,1'b1);
		go(SSE_OP_SLEEP,8'h0,1'b1);
		$display("sleep test done");
		srst_in=1;
		instr_valid_in=0;
		acc=8'h0;
		fl=3'h0;
		pre=8'h0;
		@(posedge ref_clk_in);
		#1;
		srst_in=0;
		go({6'h02,6'h25},8'h10,1'b0);
		instr_valid_in=0;
		@(posedge ref_clk_in);
		#3;
		$display("reset test done");
		results();
	end
endmodule : sleep_and_subtract_exec_bench
`default_nettype wire
